// >>> bdcfg_pkg.sv
package bdcfg_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_SETUP = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_DIGEST = 8'h08;
  localparam logic [7:0] ADR_ACTIVE = 8'h0c;
  localparam logic [7:0] ADR_STANDBY = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADR_DECODE = 8'h1c;
  // second_setup_reg fields
  localparam int SEL_LSB = 0;
  localparam int INDEP_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam logic [3:0] SETUP_RST = 4'h0;
  // command and report fields
  localparam int CLEAR_BIT = 0;
  localparam int NUM_EVENTS = 8;
  localparam int CMP_BIT = 8;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_CAPTURE_BIT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [2:0] LEVEL_RST = 3'h1;
  // six pin levels as resolved codes
  localparam logic [2:0] LVL1 = 3'h1;
  localparam logic [2:0] LVL2 = 3'h2;
  localparam logic [2:0] LVL3 = 3'h3;
  localparam logic [2:0] LVL4 = 3'h4;
  localparam logic [2:0] LVL5 = 3'h5;
  localparam logic [2:0] LVL6 = 3'h6;
  // serial select codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_LS_OFF = 2'h0;
  localparam logic [1:0] SEL_LS_ON = 2'h1;
  localparam logic [1:0] SEL_HS_OFF = 2'h2;
  localparam logic [1:0] SEL_HS_ON = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN = 3'b100
  } bdcfg_state_t;
endpackage : bdcfg_pkg

// >>> bdcfg_sync3.sv
`timescale 1ns/10ps
module bdcfg_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // three stages; a change counts only once stages two and three agree
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_out <= RST;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q_out <= s3_q;
    end
  end
endmodule : bdcfg_sync3

// >>> bdcfg_decode.sv
`timescale 1ns/10ps
module bdcfg_decode (
  input wire logic serial_in,
  input wire logic indep_in,
  input wire logic [2:0] level_in,
  input wire logic [1:0] sel_in,
  output logic olp_en_out,
  output logic high_side_out,
  output logic reg_en_out,
  output logic onstate_en_out,
  output logic retry_out
);
  // pure table lookup; the caller decides when its inputs may change
  always_comb
  begin
    olp_en_out = 1'b1;
    high_side_out = 1'b0;
    reg_en_out = 1'b1;
    onstate_en_out = 1'b1;
    retry_out = 1'b0;
    if (serial_in && !indep_in)
      olp_en_out = (sel_in != bdcfg_pkg::SEL_OFF);
    else if (serial_in)
    begin
      case (sel_in)
        bdcfg_pkg::SEL_LS_OFF: olp_en_out = 1'b0;
        bdcfg_pkg::SEL_HS_OFF: olp_en_out = 1'b0;
        default: olp_en_out = 1'b1;
      endcase
      high_side_out = sel_in[1];
      reg_en_out = !sel_in[1];
      onstate_en_out = sel_in[1];
    end
    else
    begin
      case (level_in)
        bdcfg_pkg::LVL1:
        begin
          olp_en_out = 1'b0;
          retry_out = 1'b1;
        end
        bdcfg_pkg::LVL5: olp_en_out = 1'b0;
        bdcfg_pkg::LVL4: retry_out = indep_in;
        bdcfg_pkg::LVL6: retry_out = indep_in;
        default: retry_out = 1'b0;
      endcase
      // high-side levels exist only for two half-bridges
      if (indep_in && (level_in == bdcfg_pkg::LVL3 ||
          level_in == bdcfg_pkg::LVL4))
      begin
        high_side_out = 1'b1;
        reg_en_out = 1'b0;
      end
    end
  end
endmodule : bdcfg_decode

// >>> bdcfg_top.sv
// Functional notes
// - hardwired pin is read as one of six levels, each a fixed setup
// - full bridge: level1 off+retry, level5 off+latch, others on+latch
// - half bridges: levels 3,4 high-side no regulation; 1,4,6 retry
// - hardwired level captured only at init after reset or wake
// - serial variant keeps a two-bit select field in the setup register
// - full bridge serial: code 00 disables off-state checks, others enable
// - half bridges serial: four codes pick load side and off-state check
// - serial select field takes effect at once when written
// - any fault pulls the open-drain alarm line low, except while the comparator drives the line in off-state checks
// - entering sleep releases the alarm line
// - serial: line is inverse of summary, or comparator when locked during off-state checks
// - serial: asserted faults are logged in summary and reports
// - logs cleared only by clear command or sleep request
// - one word read gives active report or standby report
// - each fault event has its own report bit
`timescale 1ns/10ps
module bdcfg_top (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic [2:0] LOAD_CHECK_CONFIG_PIN_IN,
  input wire logic LOW_POWER_REQUEST_N_IN,
  input wire logic MODE_INDEPENDENT_IN,
  input wire logic SERIAL_VARIANT_IN,
  input wire logic OFFSTATE_CMP_IN,
  input wire logic STATE_ACTIVE_IN,
  input wire logic [7:0] FAULT_EVENTS_IN,
  output logic ALARM_LINE_N_OUT,
  output logic ALARM_LINE_N_OE_OUT,
  output logic OFFSTATE_LOAD_CHECK_EN_OUT,
  output logic HIGH_SIDE_LOAD_OUT,
  output logic CURRENT_LIMIT_REGULATION_EN_OUT,
  output logic ONSTATE_CHECK_EN_OUT,
  output logic FAULT_RETRY_OUT,
  output logic IRQ_OUT
);
  localparam int NE = bdcfg_pkg::NUM_EVENTS;
  localparam logic [6:0] PIN_RST = 7'h10;

  logic [6:0] pins_s;
  logic [2:0] level_s;
  logic sleep_n_s;
  logic indep_s;
  logic serial_s;
  logic cmp_s;
  bdcfg_pkg::bdcfg_state_t state_q;
  logic [2:0] level_q;
  logic serial_q;
  logic [3:0] setup_q;
  logic [1:0] mask_q;
  logic [1:0] irq_stat_q;
  logic [NE-1:0] active_log_q;
  logic [NE-1:0] standby_log_q;
  logic [NE-1:0] events_q;
  logic awready_q;
  logic wready_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic alarm_n_q;
  logic alarm_oe_q;
  logic olp_q;
  logic hs_q;
  logic reg_q;
  logic ona_q;
  logic retry_q;
  logic irq_q;

  // pin inputs pass the three-stage filter; fault events are local logic
  bdcfg_sync3 #(
    .W(7),
    .RST(PIN_RST)
  ) u_pins (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .d_in({LOAD_CHECK_CONFIG_PIN_IN, LOW_POWER_REQUEST_N_IN,
           MODE_INDEPENDENT_IN, SERIAL_VARIANT_IN, OFFSTATE_CMP_IN}),
    .q_out(pins_s)
  );
  assign level_s = pins_s[6:4];
  assign sleep_n_s = pins_s[3];
  assign indep_s = pins_s[2];
  assign serial_s = pins_s[1];
  assign cmp_s = pins_s[0];

  // bus handshakes and decoded strobes
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic wr_low;
  logic wr_known;
  logic rd_known;
  logic wr_setup;
  logic wr_cmd;
  logic wr_mask;
  logic rd_irq;
  logic clear_cmd;
  assign aw_hs = AWVALID_IN && awready_q;
  assign w_hs = WVALID_IN && wready_q;
  assign ar_hs = ARVALID_IN && arready_q;
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign wr_low = do_write && wstrb_q[0];
  assign wr_setup = wr_low && awaddr_q == bdcfg_pkg::ADR_SETUP;
  assign wr_cmd = wr_low && awaddr_q == bdcfg_pkg::ADR_CMD;
  assign wr_mask = wr_low && awaddr_q == bdcfg_pkg::ADR_IRQ_MASK;
  assign rd_irq = ar_hs && ARADDR_IN == bdcfg_pkg::ADR_IRQ_STAT;
  assign clear_cmd = wr_cmd && wdata_q[bdcfg_pkg::CLEAR_BIT];

  // mapped addresses: all eight words, aligned
  assign wr_known = awaddr_q[1:0] == 2'h0 && awaddr_q <= bdcfg_pkg::ADR_DECODE;
  assign rd_known = ARADDR_IN[1:0] == 2'h0 && ARADDR_IN <= bdcfg_pkg::ADR_DECODE;

  // write channels: address and data taken in either order, then answered
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= bdcfg_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= AWADDR_IN;
        awready_q <= 1'b0;
      end
      if (w_hs)
      begin
        w_got_q <= 1'b1;
        wdata_q <= WDATA_IN;
        wstrb_q <= WSTRB_IN;
        wready_q <= 1'b0;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? bdcfg_pkg::RESP_OKAY : bdcfg_pkg::RESP_SLVERR;
      end
      // readies stay low until the answer is taken: one write at a time
      if (bvalid_q && BREADY_IN)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read data mux, sampled on the address handshake
  logic [31:0] rd_mux;
  logic fault_sum;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (ARADDR_IN)
      bdcfg_pkg::ADR_SETUP: rd_mux[3:0] = setup_q;
      bdcfg_pkg::ADR_DIGEST:
        rd_mux[2:0] = {|standby_log_q, |active_log_q, fault_sum};
      bdcfg_pkg::ADR_ACTIVE: rd_mux[NE-1:0] = active_log_q;
      bdcfg_pkg::ADR_STANDBY:
      begin
        rd_mux[NE-1:0] = standby_log_q;
        rd_mux[bdcfg_pkg::CMP_BIT] = cmp_s;
      end
      bdcfg_pkg::ADR_IRQ_STAT: rd_mux[1:0] = irq_stat_q;
      bdcfg_pkg::ADR_IRQ_MASK: rd_mux[1:0] = mask_q;
      bdcfg_pkg::ADR_DECODE:
        rd_mux[8:0] = {retry_q, ona_q, reg_q, hs_q, olp_q, serial_q, level_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= bdcfg_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? bdcfg_pkg::RESP_OKAY : bdcfg_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && RREADY_IN)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // power state: sleep, one init cycle after wake or reset, then run
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      state_q <= bdcfg_pkg::ST_SLEEP;
    else
    begin
      case (state_q)
        bdcfg_pkg::ST_SLEEP:
          if (sleep_n_s)
            state_q <= bdcfg_pkg::ST_INIT;
        bdcfg_pkg::ST_INIT:
          state_q <= bdcfg_pkg::ST_RUN;
        bdcfg_pkg::ST_RUN:
          if (!sleep_n_s)
            state_q <= bdcfg_pkg::ST_SLEEP;
        default: state_q <= bdcfg_pkg::ST_SLEEP;
      endcase
    end
  end

  // level and variant strap are caught in init only; later pin moves ignored
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      level_q <= bdcfg_pkg::LEVEL_RST;
      serial_q <= 1'b0;
    end
    else if (state_q == bdcfg_pkg::ST_INIT)
    begin
      level_q <= level_s;
      serial_q <= serial_s;
    end
  end

  // software setup and mask; the select field acts in the next cycle
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      setup_q <= bdcfg_pkg::SETUP_RST;
      mask_q <= bdcfg_pkg::MASK_RST;
    end
    else
    begin
      if (wr_setup)
        setup_q <= wdata_q[3:0];
      if (wr_mask)
        mask_q <= wdata_q[1:0];
    end
  end

  // configuration decode; mode comes from the pin or from the setup bit
  logic indep_mode;
  logic olp_d;
  logic hs_d;
  logic reg_d;
  logic ona_d;
  logic retry_d;
  assign indep_mode = serial_q ? setup_q[bdcfg_pkg::INDEP_BIT] : indep_s;
  bdcfg_decode u_decode (
    .serial_in(serial_q),
    .indep_in(indep_mode),
    .level_in(level_q),
    .sel_in(setup_q[bdcfg_pkg::SEL_LSB +: 2]),
    .olp_en_out(olp_d),
    .high_side_out(hs_d),
    .reg_en_out(reg_d),
    .onstate_en_out(ona_d),
    .retry_out(retry_d)
  );

  // decoded settings registered for the outputs
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      olp_q <= 1'b0;
      hs_q <= 1'b0;
      reg_q <= 1'b0;
      ona_q <= 1'b0;
      retry_q <= 1'b0;
    end
    else
    begin
      olp_q <= olp_d;
      hs_q <= hs_d;
      reg_q <= reg_d;
      ona_q <= ona_d;
      retry_q <= retry_d;
    end
  end

  // fault logs: events land in the report of the current state
  logic running;
  logic log_clear;
  logic [NE-1:0] act_set;
  logic [NE-1:0] stb_set;
  assign running = state_q == bdcfg_pkg::ST_RUN;
  assign log_clear = clear_cmd || state_q == bdcfg_pkg::ST_SLEEP;
  assign act_set = running && STATE_ACTIVE_IN ? FAULT_EVENTS_IN : '0;
  assign stb_set = running && !STATE_ACTIVE_IN ? FAULT_EVENTS_IN : '0;
  assign fault_sum = |active_log_q || |standby_log_q;

  // a set in the clearing cycle survives the clear
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      active_log_q <= '0;
      standby_log_q <= '0;
      events_q <= '0;
    end
    else
    begin
      active_log_q <= (log_clear ? '0 : active_log_q) | act_set;
      standby_log_q <= (log_clear ? '0 : standby_log_q) | stb_set;
      events_q <= running ? FAULT_EVENTS_IN : '0;
    end
  end

  // alarm line request; comparator takes over during off-state checks, in serial only when locked
  logic olp_phase;
  logic alarm_on;
  assign olp_phase = olp_q && !STATE_ACTIVE_IN;
  always_comb
  begin
    alarm_on = 1'b0;
    if (!running)
      alarm_on = 1'b0;
    else if (serial_q && olp_phase && setup_q[bdcfg_pkg::LOCK_BIT])
      alarm_on = !cmp_s;
    else if (serial_q)
      alarm_on = fault_sum;
    else if (olp_phase)
      alarm_on = !cmp_s;
    else
      alarm_on = retry_q ? |events_q : fault_sum;
  end

  // open drain: enable high while pulling low
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      alarm_n_q <= 1'b1;
      alarm_oe_q <= 1'b0;
    end
    else
    begin
      alarm_n_q <= !alarm_on;
      alarm_oe_q <= alarm_on;
    end
  end

  // sticky interrupt causes, cleared by reading; new cause beats the read
  logic [1:0] irq_set;
  assign irq_set[bdcfg_pkg::IRQ_FAULT_BIT] =
    |((act_set & ~active_log_q) | (stb_set & ~standby_log_q));
  assign irq_set[bdcfg_pkg::IRQ_CAPTURE_BIT] = state_q == bdcfg_pkg::ST_INIT;
  always_ff @(posedge CLOCK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (rd_irq ? 2'h0 : irq_stat_q) | irq_set;
      irq_q <= |(irq_stat_q & mask_q);
    end
  end

  assign AWREADY_OUT = awready_q;
  assign WREADY_OUT = wready_q;
  assign BVALID_OUT = bvalid_q;
  assign BRESP_OUT = bresp_q;
  assign ARREADY_OUT = arready_q;
  assign RVALID_OUT = rvalid_q;
  assign RDATA_OUT = rdata_q;
  assign RRESP_OUT = rresp_q;
  assign ALARM_LINE_N_OUT = alarm_n_q;
  assign ALARM_LINE_N_OE_OUT = alarm_oe_q;
  assign OFFSTATE_LOAD_CHECK_EN_OUT = olp_q;
  assign HIGH_SIDE_LOAD_OUT = hs_q;
  assign CURRENT_LIMIT_REGULATION_EN_OUT = reg_q;
  assign ONSTATE_CHECK_EN_OUT = ona_q;
  assign FAULT_RETRY_OUT = retry_q;
  assign IRQ_OUT = irq_q;
endmodule : bdcfg_top

// >>> bdcfg_chk_sva.sv
`timescale 1ns/10ps
module bdcfg_chk (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic AWVALID_IN,
  input wire logic AWREADY_OUT,
  input wire logic WVALID_IN,
  input wire logic WREADY_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic LOW_POWER_REQUEST_N_IN,
  input wire logic SERIAL_VARIANT_IN,
  input wire logic STATE_ACTIVE_IN,
  input wire logic [7:0] FAULT_EVENTS_IN,
  input wire logic ALARM_LINE_N_OUT,
  input wire logic ALARM_LINE_N_OE_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  // awake long enough for the pin filter and init to have passed
  sequence awake_s;
    (LOW_POWER_REQUEST_N_IN && SERIAL_VARIANT_IN) [*8];
  endsequence
  chk_event_alarm: assert property (awake_s ##0 (STATE_ACTIVE_IN &&
    FAULT_EVENTS_IN != 8'h00) |-> ##2 ALARM_LINE_N_OE_OUT [*2])
    else $error("fault event did not pull the alarm line");
  chk_sleep_release: assert property (!LOW_POWER_REQUEST_N_IN [*8]
    |-> !ALARM_LINE_N_OE_OUT)
    else $error("alarm line still pulled in sleep");
  chk_oe_level: assert property (ALARM_LINE_N_OUT == !ALARM_LINE_N_OE_OUT)
    else $error("alarm level and enable disagree");
  chk_read_answer: assert property (ARVALID_IN && ARREADY_OUT
    |=> RVALID_OUT && !ARREADY_OUT)
    else $error("read answer late");
  chk_rdata_hold: assert property (RVALID_OUT && !RREADY_IN
    |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped before taken");
  chk_read_rearm: assert property (RVALID_OUT && RREADY_IN
    |=> !RVALID_OUT && ARREADY_OUT)
    else $error("read channel not rearmed");
  chk_write_answer: assert property (AWVALID_IN && AWREADY_OUT &&
    WVALID_IN && WREADY_OUT |=> !BVALID_OUT ##1 BVALID_OUT)
    else $error("write answer not two cycles on");
  chk_bvalid_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
    else $error("write answer dropped before taken");
  cover property (ARVALID_IN && ARREADY_OUT);
  cover property (BVALID_OUT && BREADY_IN);
  cover property ($fell(ALARM_LINE_N_OUT));
endmodule : bdcfg_chk

bind bdcfg_top bdcfg_chk u_chk (.CLOCK_IN, .RESET_IN, .AWVALID_IN,
  .AWREADY_OUT, .WVALID_IN, .WREADY_OUT, .BVALID_OUT, .BREADY_IN,
  .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RVALID_OUT, .RREADY_IN,
  .LOW_POWER_REQUEST_N_IN, .SERIAL_VARIANT_IN, .STATE_ACTIVE_IN,
  .FAULT_EVENTS_IN, .ALARM_LINE_N_OUT, .ALARM_LINE_N_OE_OUT);

// >>> bdcfg_host.sv
`timescale 1ns/10ps
module bdcfg_host (
  input wire logic clk_in,
  input wire logic alarm_oe_in,
  output logic [2:0] level_out,
  output logic sleep_n_out,
  output logic indep_out,
  output logic serial_out,
  output logic cmp_out,
  output logic active_out,
  output logic alarm_line_out
);
  logic drv_disable_q;
  logic bridge_in_q;
  // board pull-up: the wire is low only while the device pulls it
  assign alarm_line_out = alarm_oe_in ? 1'b0 : 1'b1;
  initial
  begin
    level_out = 3'h1;
    sleep_n_out = 1'b1;
    indep_out = 1'b0;
    serial_out = 1'b0;
    cmp_out = 1'b1;
    active_out = 1'b0;
    drv_disable_q = 1'b0;
    bridge_in_q = 1'b0;
  end
  // pins move just after an edge; level only counts at the next wake
  task automatic pins(input logic [2:0] lvl, input logic ind, ser);
    @(posedge clk_in);
    level_out <= lvl;
    indep_out <= ind;
    serial_out <= ser;
  endtask : pins
  task automatic nap(input logic s);
    @(posedge clk_in);
    sleep_n_out <= !s;
  endtask : nap
  task automatic state(input logic act, input logic c);
    @(posedge clk_in);
    active_out <= act;
    cmp_out <= c;
  endtask : state
  // no level parks a high-side load, so the host does it by hand
  task automatic park();
    @(posedge clk_in);
    drv_disable_q <= 1'b1;
    bridge_in_q <= 1'b0;
  endtask : park
endmodule : bdcfg_host

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] events = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, oe, alarm_n, line;
  logic offstate_load_check, hs, regen, onst, retry, irq, sleep_n, indep, serial, cmp, active;
  logic hsx;
  logic [1:0] bresp, rresp, r;
  logic [2:0] level, ex;
  logic [31:0] rdata, d;
  int fail_count = 0;
  int checks = 0;

  always #5 clk = ~clk;

  bdcfg_host host (.clk_in(clk), .alarm_oe_in(oe), .level_out(level),
    .sleep_n_out(sleep_n), .indep_out(indep), .serial_out(serial),
    .cmp_out(cmp), .active_out(active), .alarm_line_out(line));

  bdcfg_top DUT (.CLOCK_IN(clk), .RESET_IN(rst), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(4'hf), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready), .LOAD_CHECK_CONFIG_PIN_IN(level),
    .LOW_POWER_REQUEST_N_IN(sleep_n), .MODE_INDEPENDENT_IN(indep),
    .SERIAL_VARIANT_IN(serial), .OFFSTATE_CMP_IN(cmp),
    .STATE_ACTIVE_IN(active), .FAULT_EVENTS_IN(events),
    .ALARM_LINE_N_OUT(alarm_n), .ALARM_LINE_N_OE_OUT(oe),
    .OFFSTATE_LOAD_CHECK_EN_OUT(offstate_load_check), .HIGH_SIDE_LOAD_OUT(hs),
    .CURRENT_LIMIT_REGULATION_EN_OUT(regen), .ONSTATE_CHECK_EN_OUT(onst),
    .FAULT_RETRY_OUT(retry), .IRQ_OUT(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ends at a falling edge so that flop outputs are settled when compared
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt

  // address and data offered together, each dropped once taken
  // handshakes are judged mid-cycle and acted on at the following edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta;
    logic tw;
    logic tk;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      n++;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    while (!tk && n < 64);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    logic ta;
    logic tk;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      n++;
      ta = arvalid && arready;
      tk = rvalid;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
    end
    while (!tk && n < 64);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // sleep long enough to pass the pin filter, then let init finish
  task automatic wake();
    host.nap(1'b1);
    wt(8);
    host.nap(1'b0);
    wt(12);
  endtask : wake

  task automatic pulse(input int i);
    @(posedge clk);
    events <= 8'h01 << i;
    @(posedge clk);
    events <= 8'h00;
    wt(4);
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(bdcfg_pkg::ADR_SETUP, d, r);
    chk(d, 32'(bdcfg_pkg::SETUP_RST));
    rd(bdcfg_pkg::ADR_IRQ_MASK, d, r);
    chk(d, 32'(bdcfg_pkg::MASK_RST));
    wr(bdcfg_pkg::ADR_SETUP, 32'hffff_fffb);
    rd(bdcfg_pkg::ADR_SETUP, d, r);
    chk(d, 32'hb);
    rd(8'h20, d, r);
    chk(32'(r), 32'(bdcfg_pkg::RESP_SLVERR));
    wr(bdcfg_pkg::ADR_SETUP, 32'h0);
    $display("test registers done");
    host.park();
    for (int m = 0; m < 2; m++)
      for (int l = 1; l < 7; l++)
      begin
        hsx = m == 1 && (l == 3 || l == 4);
        ex = {l != 1 && l != 5, hsx, l == 1 || (m == 1 && (l == 4 || l == 6))};
        host.pins(3'(l), m[0], 1'b0);
        wake();
        chk(32'({offstate_load_check, hs, retry}), 32'(ex));
        if (m == 1)
          chk(32'(regen), 32'(!hsx));
        rd(bdcfg_pkg::ADR_DECODE, d, r);
        chk(32'(d[2:0]), 32'(l));
        host.pins(3'(l % 6 + 1), m[0], 1'b0);
        wt(8);
        chk(32'({offstate_load_check, hs, retry}), 32'(ex));
      end
    $display("test pin levels done");
    host.pins(3'h1, 1'b0, 1'b1);
    wake();
    // no restart between writes: each code must show at once
    for (int k = 0; k < 8; k++)
    begin
      wr(bdcfg_pkg::ADR_SETUP, 32'(k));
      wt(3);
      chk(32'({offstate_load_check, hs, onst, retry}), 32'({k[2] ? k[0] : k[1:0] != 2'h0,
        k[2] & k[1], k[2] ? k[1] : 1'b1, 1'b0}));
      if (k[2])
        chk(32'(regen), 32'(!k[1]));
    end
    $display("test select field done");
    wr(bdcfg_pkg::ADR_SETUP, 32'h0);
    host.state(1'b1, 1'b1);
    wr(bdcfg_pkg::ADR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      pulse(i);
      chk(32'(line), 32'h0);
      chk(32'(irq), 32'h1);
      rd(bdcfg_pkg::ADR_ACTIVE, d, r);
      chk(d, 32'h1 << i);
      rd(bdcfg_pkg::ADR_DIGEST, d, r);
      chk(32'(d[0]), 32'h1);
      rd(bdcfg_pkg::ADR_ACTIVE, d, r);
      chk(d, 32'h1 << i);
      rd(bdcfg_pkg::ADR_IRQ_STAT, d, r);
      wt(2);
      chk(32'(irq), 32'h0);
      wr(bdcfg_pkg::ADR_CMD, 32'h1);
      wt(3);
      chk(32'(line), 32'h1);
    end
    wr(bdcfg_pkg::ADR_IRQ_MASK, 32'h0);
    pulse(3);
    chk(32'(irq), 32'h0);
    host.state(1'b0, 1'b1);
    pulse(2);
    rd(bdcfg_pkg::ADR_STANDBY, d, r);
    chk(32'(d[7:0]), 32'h04);
    $display("test fault logging done");
    host.nap(1'b1);
    wt(10);
    chk(32'(line), 32'h1);
    host.nap(1'b0);
    wt(12);
    rd(bdcfg_pkg::ADR_STANDBY, d, r);
    chk(32'(d[7:0]), 32'h0);
    // locked override with checks on: the line follows the comparator
    wr(bdcfg_pkg::ADR_SETUP, 32'h9);
    wt(8);
    chk(32'(line), 32'h1);
    host.state(1'b0, 1'b0);
    wt(8);
    chk(32'(line), 32'h0);
    wr(bdcfg_pkg::ADR_SETUP, 32'h1);
    wt(4);
    chk(32'(line), 32'h1);
    $display("test sleep and comparator done");
    stop_test();
  end

  // the whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : tb_top
